// ==== rtl/vpc_pkg.sv ====
// shared constants, modes and carriers for the virtual address privilege checker
package vpc_pkg;

  // ==========================================================================
  // sizes
  localparam int VA_W        = 64;
  localparam int XLAT_W      = 44;
  localparam int MASK_W      = 12;
  localparam int OFS_MIN     = 12;
  localparam int OFS_MAX     = 24;
  localparam int ENTRIES_DEF = 8;
  localparam int ENTRY_AW    = $clog2(ENTRIES_DEF);
  localparam int IRQ_W       = 2;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_FAULT_LO = 8'h0C;
  localparam logic [7:0] ADDR_FAULT_HI = 8'h10;
  localparam logic [7:0] ADDR_MASK_WIN = 8'h40;

  // ==========================================================================
  // field positions and reset values
  localparam int          ST_FAULT    = 0;
  localparam int          ST_BADMASK  = 1;
  localparam logic [5:0]  CTRL_RST    = 6'h00;
  localparam logic [1:0]  IRQ_RST     = 2'h0;
  localparam logic [11:0] MASK_RST    = 12'h000;

  // ==========================================================================
  // address map boundaries
  localparam logic [31:0] K32_BASE    = 32'h8000_0000;
  localparam logic [31:0] SSEG_BASE   = 32'hC000_0000;
  localparam logic [31:0] KSEG3_BASE  = 32'hE000_0000;
  localparam logic [1:0]  SEG_USER    = 2'b00;
  localparam logic [1:0]  SEG_SUPER   = 2'b01;
  localparam logic [1:0]  SEG_PHYS    = 2'b10;
  localparam logic [11:0] XKSEG_LIMIT = 12'hFFF;

  typedef enum logic [1:0] {
    VPC_KERNEL = 2'b00,
    VPC_SUPER  = 2'b01,
    VPC_USER   = 2'b10
  } vpc_mode_e;

  typedef struct packed {
    logic      error_level;
    logic      wide_supervisor_enable;
    logic      wide_user_enable;
    logic      addr64;
    vpc_mode_e mode;
  } vpc_ctrl_s;

  typedef struct packed {
    logic [VA_W-1:0]     vaddr;
    logic [ENTRY_AW-1:0] entry;
    logic                is_data;
  } vpc_req_s;

  typedef struct packed {
    logic                address_fault;
    logic                unmapped;
    logic                odd_page;
    logic [XLAT_W-1:0]   vpn2;
    logic [OFS_MAX-1:0]  offset;
  } vpc_resp_s;

endpackage : vpc_pkg

// ==== rtl/vpc_page_split.sv ====
// page size decode: splits an address into page pair number, odd select and offset
`timescale 1ns/1ps
module vpc_page_split
  import vpc_pkg::*;
(
  input  wire logic [MASK_W-1:0]  page_size_mask,
  input  wire logic [XLAT_W-1:0]  vaddr,
  output logic                    legal,
  output logic                    odd_page,
  output logic [XLAT_W-1:0]       vpn2,
  output logic [OFS_MAX-1:0]      offset
);

  logic [2:0]        pairs;
  logic              done;
  logic [4:0]        ofs_bits;
  logic [XLAT_W-1:0] ofs_mask;

  // each set pair of mask bits quadruples the page; decode stops at first gap
  always_comb
  begin
    pairs = 3'd0;
    done  = 1'b0;
    for (int i = 0; i < MASK_W / 2; i++)
    begin
      if (!done && page_size_mask[2*i +: 2] == 2'b11)
      begin
        pairs = pairs + 3'd1;
      end
      else
      begin
        done = 1'b1;
      end
    end
  end

  assign ofs_bits = 5'(OFS_MIN + 2 * pairs);
  assign legal    = (page_size_mask == MASK_W'((32'd1 << (2 * pairs)) - 32'd1));
  assign ofs_mask = XLAT_W'((64'd1 << ofs_bits) - 64'd1);
  assign offset   = OFS_MAX'(vaddr & ofs_mask);
  assign odd_page = vaddr[ofs_bits];
  assign vpn2     = vaddr & ~{ofs_mask[XLAT_W-2:0], 1'b1};

endmodule : vpc_page_split

// ==== rtl/vpc_mask_mem.sv ====
// per-entry page size mask store with one write and two registered read ports
`timescale 1ns/1ps
module vpc_mask_mem
  import vpc_pkg::*;
#(
  parameter int WIDTH = MASK_W,
  parameter int DEPTH = ENTRIES_DEF,
  parameter int AW    = $clog2(DEPTH)
)
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr_a,
  output logic [WIDTH-1:0]      rdata_a,
  input  wire logic [AW-1:0]    raddr_b,
  output logic [WIDTH-1:0]      rdata_b
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  // small enough to reset: every entry starts at the smallest page
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_r[i] <= WIDTH'(MASK_RST);
      end
    end
    else if (we)
    begin
      mem_r[waddr] <= wdata;
    end
  end

  // reads return the old word when written in the same cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_a <= '0;
      rdata_b <= '0;
    end
    else
    begin
      rdata_a <= mem_r[raddr_a];
      rdata_b <= mem_r[raddr_b];
    end
  end

endmodule : vpc_mask_mem

// ==== rtl/vpc_checker.sv ====
// virtual address privilege checker with page split and apb register file
// ==========================================================================
// Notes on behaviour
// - wide_user_enable clear: 64-bit supervisor/kernel reach only 32-bit user region
// - wide_supervisor_enable clear: 64-bit kernel faults the wide supervisor space
// - any access not permitted raises address_fault instead of completing
// - 32-bit map: low half open, C0..DF supervisor+kernel, rest kernel only
// - 32-bit user data references clear upper address half before checking
// - page size per entry from 4 KB to 16 MB in steps of four
// - 12 to 24 low offset bits pass untranslated, upper bits translated
// - entry maps a page pair; lowest page number bit picks the page
// - page size comes from the entry's own software written mask
// - 64-bit kernel with error_level: user space is 2 GB and unmapped
// - 64-bit kernel: address bits 63:62 pick user, supervisor, physical, kernel
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module vpc_checker
  import vpc_pkg::*;
#(
  parameter int ENTRIES = ENTRIES_DEF
)
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        req_valid,
  input  wire vpc_req_s    req,
  output logic             resp_valid,
  output vpc_resp_s        resp,
  output logic             irq
);

  // ==========================================================================
  // declarations
  vpc_ctrl_s         ctrl_r;
  logic [IRQ_W-1:0]  irq_status_r;
  logic [IRQ_W-1:0]  irq_status_nxt;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [IRQ_W-1:0]  irq_mask_nxt;
  logic [IRQ_W-1:0]  irq_event;
  logic [VA_W-1:0]   fault_addr_r;
  logic [31:0]       prdata_r;
  logic              pready_r;
  logic              pslverr_r;
  logic              irq_r;
  logic              s1_v_r;
  vpc_req_s          s1_req_r;
  logic              resp_valid_r;
  vpc_resp_s         resp_r;
  logic [VA_W-1:0]   chk_eff_r;

  logic              acc;
  logic              wr_go;
  logic              hit_ctrl;
  logic              hit_status;
  logic              hit_mask_reg;
  logic              hit_flo;
  logic              hit_fhi;
  logic              hit_win;
  logic              mapped;
  logic [31:0]       rd_data_w;
  logic [MASK_W-1:0] mask_rd;
  logic [MASK_W-1:0] mask_apb;
  logic              wr_mask_legal;

  logic              is_kern;
  logic              is_super;
  logic              is_user;
  logic [VA_W-1:0]   eff;
  logic [1:0]        seg;
  logic              sext32;
  logic              ok32;
  logic              lo2g;
  logic              xuser;
  logic              xsup;
  logic              comp;
  logic              csup;
  logic              ok_u64;
  logic              ok_s64;
  logic              k_user;
  logic              k_sup;
  logic              k_kern;
  logic              ok_k64;
  logic              fault_w;
  logic              unmapped_w;
  logic              odd_w;
  logic [XLAT_W-1:0] vpn2_w;
  logic [OFS_MAX-1:0] offset_w;

  // ==========================================================================
  // apb decode
  assign acc          = psel && penable;
  assign wr_go        = acc && pwrite && pready_r;
  assign hit_ctrl     = (paddr == ADDR_CTRL);
  assign hit_status   = (paddr == ADDR_STATUS);
  assign hit_mask_reg = (paddr == ADDR_IRQ_MASK);
  assign hit_flo      = (paddr == ADDR_FAULT_LO);
  assign hit_fhi      = (paddr == ADDR_FAULT_HI);
  assign hit_win      = (paddr[7:5] == ADDR_MASK_WIN[7:5]) && (paddr[1:0] == 2'b00);
  assign mapped       = hit_ctrl || hit_status || hit_mask_reg || hit_flo || hit_fhi
                        || hit_win;

  always_comb
  begin
    rd_data_w = 32'h0000_0000;
    if (hit_ctrl)
    begin
      rd_data_w = 32'(ctrl_r);
    end
    else if (hit_status)
    begin
      rd_data_w = 32'(irq_status_r);
    end
    else if (hit_mask_reg)
    begin
      rd_data_w = 32'(irq_mask_r);
    end
    else if (hit_flo)
    begin
      rd_data_w = fault_addr_r[31:0];
    end
    else if (hit_fhi)
    begin
      rd_data_w = fault_addr_r[63:32];
    end
    else if (hit_win)
    begin
      rd_data_w = 32'(mask_apb);
    end
  end

  // one wait state: the window read port is addressed during setup
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= acc && !pready_r;
      pslverr_r <= acc && !pready_r && !mapped;
      if (acc && !pready_r)
      begin
        prdata_r <= pwrite ? 32'h0000_0000 : rd_data_w;
      end
    end
  end

  // ==========================================================================
  // control and interrupt registers
  assign irq_event[ST_FAULT]   = resp_valid_r && resp_r.address_fault;
  assign irq_event[ST_BADMASK] = wr_go && hit_win && !wr_mask_legal;
  // a new event wins over a write-one clear in the same cycle
  assign irq_status_nxt = (irq_status_r & ~((wr_go && hit_status) ? pwdata[IRQ_W-1:0]
                          : '0)) | irq_event;
  assign irq_mask_nxt   = (wr_go && hit_mask_reg) ? pwdata[IRQ_W-1:0] : irq_mask_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_r       <= vpc_ctrl_s'(CTRL_RST);
      irq_status_r <= IRQ_RST;
      irq_mask_r   <= IRQ_RST;
      irq_r        <= 1'b0;
    end
    else
    begin
      if (wr_go && hit_ctrl)
      begin
        ctrl_r <= vpc_ctrl_s'(pwdata[5:0]);
      end
      irq_status_r <= irq_status_nxt;
      irq_mask_r   <= irq_mask_nxt;
      irq_r        <= |(irq_status_nxt & irq_mask_nxt);
    end
  end

  // ==========================================================================
  // per-entry page size masks, written and read back through the window
  vpc_mask_mem #(
    .WIDTH (MASK_W),
    .DEPTH (ENTRIES)
  ) u_mask_mem (
    .clk     (clk),
    .reset_n (reset_n),
    .we      (wr_go && hit_win),
    .waddr   (paddr[4:2]),
    .wdata   (pwdata[MASK_W-1:0]),
    .raddr_a (req.entry),
    .rdata_a (mask_rd),
    .raddr_b (paddr[4:2]),
    .rdata_b (mask_apb)
  );

  vpc_page_split u_wr_check (
    .page_size_mask (pwdata[MASK_W-1:0]),
    .vaddr          ('0),
    .legal          (wr_mask_legal),
    .odd_page       (),
    .vpn2           (),
    .offset         ()
  );

  // ==========================================================================
  // request stage: mask read lines up with the captured request
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_v_r   <= 1'b0;
      s1_req_r <= '0;
    end
    else
    begin
      s1_v_r <= req_valid;
      if (req_valid)
      begin
        s1_req_r <= req;
      end
    end
  end

  // ==========================================================================
  // privilege check
  assign is_kern  = (ctrl_r.mode == VPC_KERNEL);
  assign is_super = (ctrl_r.mode == VPC_SUPER);
  assign is_user  = !is_kern && !is_super;
  assign eff      = (!ctrl_r.addr64 && is_user && s1_req_r.is_data)
                    ? {32'h0000_0000, s1_req_r.vaddr[31:0]} : s1_req_r.vaddr;
  assign seg      = eff[63:62];
  assign sext32   = (eff[63:32] == {32{eff[31]}});
  assign ok32     = sext32 && ((eff[31:0] < K32_BASE) || is_kern
                    || (is_super && eff[31:0] >= SSEG_BASE
                        && eff[31:0] < KSEG3_BASE));
  assign lo2g     = (eff[63:31] == 33'h0_0000_0000);
  assign xuser    = (eff[63:XLAT_W] == '0);
  assign xsup     = (eff[63:XLAT_W] == {SEG_SUPER, 18'h0_0000});
  assign comp     = (eff[63:31] == {33{1'b1}});
  assign csup     = comp && (eff[31:0] >= SSEG_BASE) && (eff[31:0] < KSEG3_BASE);
  assign ok_u64   = xuser;
  assign ok_s64   = lo2g || (xuser && ctrl_r.wide_user_enable) || xsup || csup;
  assign k_user   = lo2g || (xuser && ctrl_r.wide_user_enable
                    && !ctrl_r.error_level);
  assign k_sup    = xsup && ctrl_r.wide_supervisor_enable;
  assign k_kern   = comp || (eff[61:XLAT_W] == '0 && eff[43:32] != XKSEG_LIMIT);
  // physical window is admitted whole; its cache algorithm decode lives elsewhere
  assign ok_k64   = (seg == SEG_USER) ? k_user : (seg == SEG_SUPER) ? k_sup
                    : (seg == SEG_PHYS) ? 1'b1 : k_kern;
  assign fault_w  = !(ctrl_r.addr64 ? (is_kern ? ok_k64 : is_super ? ok_s64 : ok_u64)
                    : ok32);
  assign unmapped_w = ctrl_r.addr64 && is_kern && ctrl_r.error_level && lo2g;

  vpc_page_split u_split (
    .page_size_mask (mask_rd),
    .vaddr          (eff[XLAT_W-1:0]),
    .legal          (),
    .odd_page       (odd_w),
    .vpn2           (vpn2_w),
    .offset         (offset_w)
  );

  // ==========================================================================
  // answer stage
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      resp_valid_r <= 1'b0;
      resp_r       <= '0;
      fault_addr_r <= '0;
      chk_eff_r    <= '0;
    end
    else
    begin
      resp_valid_r <= s1_v_r;
      chk_eff_r    <= eff;
      if (s1_v_r)
      begin
        resp_r <= '{address_fault: fault_w, unmapped: unmapped_w, odd_page: odd_w,
                    vpn2: vpn2_w, offset: offset_w};
      end
      if (s1_v_r && fault_w)
      begin
        fault_addr_r <= eff;
      end
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign resp_valid = resp_valid_r;
  assign resp       = resp_r;
  assign irq        = irq_r;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence fault_out_s;
    s1_v_r && fault_w ##1 resp_valid_r && resp_r.address_fault;
  endsequence

  fault_irq_a: assert property (fault_out_s |=> irq_status_r[ST_FAULT])
    else $error("address fault did not set status");
  user32_k_a: assert property (s1_v_r && !ctrl_r.addr64 && is_user && eff[31]
    |=> resp_valid_r && resp_r.address_fault)
    else $error("32-bit user reached upper half");
  sup32_s_a: assert property (s1_v_r && !ctrl_r.addr64 && is_super
    && eff[63:29] == {{34{1'b1}}, 1'b0} |=> !resp_r.address_fault)
    else $error("32-bit supervisor refused its region");
  user_data_a: assert property (s1_v_r && !ctrl_r.addr64 && is_user
    && s1_req_r.is_data && !s1_req_r.vaddr[31] |=> !resp_r.address_fault)
    else $error("upper half not cleared");
  wide_user_a: assert property (s1_v_r && ctrl_r.addr64 && !is_user
    && !ctrl_r.wide_user_enable && xuser && !lo2g |=> resp_r.address_fault)
    else $error("wide user space reached");
  wide_sup_a: assert property (s1_v_r && ctrl_r.addr64 && is_kern
    && !ctrl_r.wide_supervisor_enable && seg == SEG_SUPER |=> resp_r.address_fault)
    else $error("wide supervisor space reached");
  erl_low_a: assert property (s1_v_r && ctrl_r.addr64 && is_kern
    && ctrl_r.error_level && eff[63:31] == 33'h0_0000_0000
    |=> resp_r.unmapped && !resp_r.address_fault)
    else $error("error level low region wrong");
  seg_sup_a: assert property (s1_v_r && ctrl_r.addr64 && is_kern
    && ctrl_r.wide_supervisor_enable && eff[63:XLAT_W] == {2'b01, 18'h0_0000}
    |=> !resp_r.address_fault)
    else $error("supervisor segment refused");
  user64_a: assert property (s1_v_r && ctrl_r.addr64 && is_user
    && eff[63:XLAT_W] != '0 |=> resp_r.address_fault)
    else $error("64-bit user left its region");
  big_page_a: assert property (s1_v_r && mask_rd == 12'hFFF
    |=> resp_r.offset == chk_eff_r[23:0] && resp_r.vpn2[24:0] == 25'h000_0000)
    else $error("16 MB page offset wrong");
  mid_page_a: assert property (s1_v_r && mask_rd == 12'h00F
    |=> resp_r.offset == {8'h00, chk_eff_r[15:0]})
    else $error("64 KB page offset wrong");
  odd_sel_a: assert property (s1_v_r && mask_rd == 12'h003
    |=> resp_r.odd_page == chk_eff_r[14] && resp_r.vpn2[14:0] == 15'h0000)
    else $error("odd page select wrong");

endmodule : vpc_checker

// ==== sim/vpc_core_model.sv ====
// requester model of the core address calculation side
`timescale 1ns/1ps
module vpc_core_model
  import vpc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      reset_n,
  input  wire logic      go,
  input  wire vpc_req_s  go_req,
  output logic           req_valid,
  output vpc_req_s       req,
  input  wire logic      resp_valid,
  input  wire vpc_resp_s resp,
  output logic           err
);
  logic [1:0] sent_r;
  vpc_resp_s  resp_q[$];
  // ==========================================================================
  // launch and collect
  // an idle request bus shows the inverse, so a stale value never passes
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_valid <= 1'b0;
      req       <= '0;
      sent_r    <= 2'h0;
      err       <= 1'b0;
    end
    else
    begin
      req_valid <= go;
      req       <= go ? go_req : vpc_req_s'(~req);
      sent_r    <= {sent_r[0], req_valid};
      if (resp_valid !== sent_r[1])
        err <= 1'b1;
      if (resp_valid === 1'b1)
        resp_q.push_back(resp);
    end
  end
endmodule : vpc_core_model

// ==== sim/test_vpc_checker.sv ====
// self-checking bench for the virtual address privilege checker
`timescale 1ns/1ps
module test_vpc_checker
  import vpc_pkg::*;
;
  logic        clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        req_valid;
  logic        resp_valid;
  logic        irq;
  logic        go;
  logic        lat_err;
  vpc_req_s    req;
  vpc_req_s    go_req;
  vpc_resp_s   resp;
  vpc_resp_s   rs;
  logic [31:0] r;
  logic        e;
  logic [63:0] va;
  int          failures;
  int          compares;
  int          cycles;
  int          k;
  int          ob;

  vpc_checker u_vpc_checker (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req(req), .resp_valid(resp_valid),
    .resp(resp), .irq(irq));
  vpc_core_model u_vpc_core_model (.clk(clk), .reset_n(reset_n), .go(go), .go_req(go_req),
    .req_valid(req_valid), .req(req), .resp_valid(resp_valid), .resp(resp), .err(lat_err));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================================
  // tasks
  task stop_test();
    if (failures == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task chk(input string n, input logic [63:0] s, input logic [63:0] x);
    compares++;
    if (s !== x)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd_v, output logic er);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_v = prdata;
    er   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r0;
    logic        e0;
    apb(1'b1, a, d, r0, e0);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, r, e);
    chk("register read", r, x);
  endtask : rd

  // one request through the model; waits for its answer
  task issue(input logic [63:0] v, input logic [2:0] en, input logic dt);
    @(posedge clk);
    go     <= 1'b1;
    go_req <= '{vaddr: v, entry: en, is_data: dt};
    @(posedge clk);
    go <= 1'b0;
    while (u_vpc_core_model.resp_q.size() == 0)
      @(posedge clk);
    rs = u_vpc_core_model.resp_q.pop_front();
  endtask : issue

  task pcase(input logic [5:0] c, input logic [63:0] v, input logic dt, input logic f);
    logic [63:0] eff;
    eff = (c[2:0] == 3'h2 && dt) ? {32'h0, v[31:0]} : v;
    wr(ADDR_CTRL, {26'h0, c});
    issue(v, 3'h0, dt);
    chk("fault", rs.address_fault, f);
    chk("unmapped", rs.unmapped, c[5] && c[2:0] == 3'h4 && !f && v < 64'h8000_0000);
    if (f)
    begin
      rd(ADDR_FAULT_LO, eff[31:0]);
      rd(ADDR_FAULT_HI, eff[63:32]);
    end
  endtask : pcase

  // ==========================================================================
  // hang guard, sized well above the full sequence
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      failures++;
      stop_test();
    end
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    reset_n  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    go       = 1'b0;
    go_req   = '0;
    failures = 0;
    compares = 0;
    cycles   = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_IRQ_MASK, 32'h0);
    rd(ADDR_MASK_WIN, 32'h0);
    apb(1'b0, 8'h20, 32'h0, r, e);
    chk("unmapped data", r, 32'h0);
    chk("unmapped error", e, 1'b1);
    // fault event raises the interrupt, mask and clear drop it
    wr(ADDR_IRQ_MASK, 32'h1);
    pcase(6'h02, 64'hFFFF_FFFF_C000_0000, 1'b0, 1'b1);
    chk("irq raised", irq, 1'b1);
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", irq, 1'b0);
    wr(ADDR_STATUS, 32'h1);
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h2);
    wr(ADDR_MASK_WIN + 8'h1C, 32'h005);
    rd(ADDR_STATUS, 32'h2);
    chk("irq bad size", irq, 1'b1);
    rd(ADDR_MASK_WIN + 8'h1C, 32'h005);
    wr(ADDR_STATUS, 32'h2);
    wr(ADDR_IRQ_MASK, 32'h0);
    // privilege map, mode by mode
    pcase(6'h00, 64'h0000_0000_7FFF_FFFF, 1'b0, 1'b0);
    pcase(6'h00, 64'hFFFF_FFFF_8000_0000, 1'b0, 1'b0);
    pcase(6'h00, 64'h0000_0001_0000_0000, 1'b0, 1'b1);
    pcase(6'h01, 64'hFFFF_FFFF_C000_0000, 1'b0, 1'b0);
    pcase(6'h01, 64'hFFFF_FFFF_A000_0000, 1'b0, 1'b1);
    pcase(6'h01, 64'hFFFF_FFFF_E000_0000, 1'b0, 1'b1);
    pcase(6'h02, 64'h0000_0000_0000_1000, 1'b0, 1'b0);
    pcase(6'h02, 64'hFFFF_FFFF_8000_0000, 1'b1, 1'b1);
    pcase(6'h02, 64'hFFFF_FFFF_0000_3000, 1'b1, 1'b0);
    chk("cleared page", rs.vpn2, 44'h000_0000_2000);
    pcase(6'h03, 64'hFFFF_FFFF_C000_0000, 1'b0, 1'b1);
    pcase(6'h06, 64'h0000_0FFF_FFFF_FFFF, 1'b0, 1'b0);
    pcase(6'h06, 64'h0000_1000_0000_0000, 1'b0, 1'b1);
    pcase(6'h06, 64'h4000_0000_0000_0000, 1'b0, 1'b1);
    pcase(6'h05, 64'h0000_0000_8000_0000, 1'b0, 1'b1);
    pcase(6'h0D, 64'h0000_0000_8000_0000, 1'b0, 1'b0);
    pcase(6'h05, 64'h4000_0000_0000_0000, 1'b0, 1'b0);
    pcase(6'h05, 64'hFFFF_FFFF_E000_0000, 1'b0, 1'b1);
    pcase(6'h04, 64'h0000_0000_8000_0000, 1'b0, 1'b1);
    pcase(6'h0C, 64'h0000_0FFF_FFFF_FFFF, 1'b0, 1'b0);
    pcase(6'h04, 64'h4000_0000_0000_0000, 1'b0, 1'b1);
    pcase(6'h14, 64'h4000_0FFF_FFFF_FFFF, 1'b0, 1'b0);
    pcase(6'h14, 64'h4000_1000_0000_0000, 1'b0, 1'b1);
    pcase(6'h04, 64'h8000_0000_0000_0000, 1'b0, 1'b0);
    pcase(6'h04, 64'hC000_0000_0000_0000, 1'b0, 1'b0);
    pcase(6'h04, 64'hC000_0FFF_0000_0000, 1'b0, 1'b1);
    pcase(6'h04, 64'hFFFF_FFFF_E000_0000, 1'b0, 1'b0);
    pcase(6'h2C, 64'h0000_0000_8000_0000, 1'b0, 1'b1);
    pcase(6'h2C, 64'h0000_0000_0000_1000, 1'b0, 1'b0);
    // every legal page size, one entry each
    wr(ADDR_CTRL, 32'h0);
    va = 64'h0000_0000_5A5A_5A5A;
    for (k = 0; k < 7; k++)
    begin
      ob = 12 + 2 * k;
      wr(ADDR_MASK_WIN + 8'(4 * k), 32'((1 << (2 * k)) - 1));
      rd(ADDR_MASK_WIN + 8'(4 * k), 32'((1 << (2 * k)) - 1));
      issue(va, 3'(k), 1'b0);
      chk("offset", rs.offset, 24'(va & ((64'h1 << ob) - 1)));
      chk("odd page", rs.odd_page, va[ob]);
      chk("page pair", rs.vpn2, 44'(va & ~((64'h1 << (ob + 1)) - 1)));
    end
    // two requests on consecutive cycles keep their order
    wr(ADDR_CTRL, 32'h2);
    @(posedge clk);
    go     <= 1'b1;
    go_req <= '{vaddr: 64'h1000, entry: 3'h0, is_data: 1'b0};
    @(posedge clk);
    go_req <= '{vaddr: 64'hFFFF_FFFF_8000_0000, entry: 3'h0, is_data: 1'b0};
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
    chk("answers", u_vpc_core_model.resp_q.size(), 2);
    rs = u_vpc_core_model.resp_q.pop_front();
    chk("first", rs.address_fault, 1'b0);
    rs = u_vpc_core_model.resp_q.pop_front();
    chk("second", rs.address_fault, 1'b1);
    chk("answer timing", lat_err, 1'b0);
    stop_test();
  end
endmodule : test_vpc_checker
